/* File: rtl/sbp_top.sv */
// Parallel slave byte port: external processor access to the port D latch
`timescale 1ns/100ps
module sbp_top #(
    parameter int unsigned DATA_W = sbp_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Strobe port pins: read, write and select
    input  wire logic [2:0]        strobe_port_pins,
    // Byte port pins
    input  wire logic [DATA_W-1:0] byte_port_pins_in,
    output logic [DATA_W-1:0]      byte_port_pins_out,
    output logic [DATA_W-1:0]      byte_port_pins_oe,
    // Software mode and conditions
    input  wire logic              slave_port_mode_bit,
    input  wire logic              pwm_multi_output,
    input  wire logic [3:0]        converter_pin_config,
    // Software access to port D latch
    input  wire logic              latch_wr,
    input  wire logic [DATA_W-1:0] latch_wdata,
    output logic [DATA_W-1:0]      latch_rdata,
    // Software flag clears
    input  wire logic              irq_flag_clr,
    input  wire logic              input_full_clr,
    // Priority control
    input  wire logic              prio_wr,
    input  wire logic              prio_wdata,
    input  wire logic              irq_priority_enable,
    // Status
    output logic [3:0]             strobe_port_direction_hi,
    output logic                   slave_port_irq_flag,
    output logic                   input_full_flag,
    output logic                   output_full_flag,
    output logic                   slave_port_irq_priority,
    output logic                   irq_high,
    output logic                   irq_low,
    output logic                   port_active
);
    // Elaboration check: only an eight-bit port is served
    if (DATA_W != 8) begin : g_width_check
        $error("sbp_top serves an eight-bit port only");
    end

    // Reset release through two flip-flops
    logic rst_s1_reg;
    logic rst_sync_n;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_sync_n <= rst_s1_reg;
        end
    end

    logic rd_s;
    logic wr_s;
    logic cs_s;
    sbp_sync #(.STAGES(sbp_pkg::SYNC_STAGES), .INIT(1'b1)) u_sync_rd (
        .core_clk (core_clk),
        .rst_n    (rst_sync_n),
        .async_in (strobe_port_pins[sbp_pkg::RD_PIN]),
        .sync_out (rd_s)
    );
    sbp_sync #(.STAGES(sbp_pkg::SYNC_STAGES), .INIT(1'b1)) u_sync_wr (
        .core_clk (core_clk),
        .rst_n    (rst_sync_n),
        .async_in (strobe_port_pins[sbp_pkg::WR_PIN]),
        .sync_out (wr_s)
    );
    sbp_sync #(.STAGES(sbp_pkg::SYNC_STAGES), .INIT(1'b1)) u_sync_cs (
        .core_clk (core_clk),
        .rst_n    (rst_sync_n),
        .async_in (strobe_port_pins[sbp_pkg::CS_PIN]),
        .sync_out (cs_s)
    );

    // enable decode; strobe roles; strobe-timed access
    wire active_w = slave_port_mode_bit & ~pwm_multi_output;
    wire wr_low_w = active_w & ~cs_s & ~wr_s;
    wire rd_low_w = active_w & ~cs_s & ~rd_s;

    sbp_pkg::sbp_state_t state_reg;
    sbp_pkg::sbp_state_t state_next;
    logic [DATA_W-1:0]   latch_reg;
    logic                ibf_reg;
    logic                obf_reg;
    logic                irqf_reg;
    logic                prio_reg;

    // Transfer sequencing
    wire write_end_w = (state_reg == sbp_pkg::SBP_WRITE) & ~wr_low_w;
    wire read_end_w  = (state_reg == sbp_pkg::SBP_READ) & ~rd_low_w;
    wire read_start_w = (state_reg == sbp_pkg::SBP_IDLE) & rd_low_w & ~wr_low_w;

    // Next state; write wins when both strobes start together
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            sbp_pkg::SBP_IDLE: begin
                if (wr_low_w)      state_next = sbp_pkg::SBP_WRITE;
                else if (rd_low_w) state_next = sbp_pkg::SBP_READ;
            end
            sbp_pkg::SBP_WRITE: if (!wr_low_w) state_next = sbp_pkg::SBP_IDLE;
            sbp_pkg::SBP_READ:  if (!rd_low_w) state_next = sbp_pkg::SBP_IDLE;
            default:            state_next = sbp_pkg::SBP_IDLE;
        endcase
    end

    // Flag next values, set wins over clear except for output-full, where the read clear wins
    wire in_read_w = (state_reg == sbp_pkg::SBP_READ) | read_start_w;
    // write end sets both flags; read end sets irq flag
    wire irqf_next = write_end_w | read_end_w | (irqf_reg & ~irq_flag_clr);
    wire ibf_next  = write_end_w | (ibf_reg & ~input_full_clr);
    // read clears; software write during read leaves it clear
    wire obf_next  = in_read_w ? 1'b0 : (latch_wr | obf_reg);

    wire prio_next = prio_wr ? prio_wdata : prio_reg;

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg <= sbp_pkg::SBP_IDLE;
            ibf_reg   <= 1'b0;
            obf_reg   <= 1'b0;
            irqf_reg  <= 1'b0;
            prio_reg  <= sbp_pkg::PRIO_RESET;
        end else begin
            state_reg <= state_next;
            ibf_reg   <= ibf_next;
            obf_reg   <= obf_next;
            irqf_reg  <= irqf_next;
            prio_reg  <= prio_next;
        end
    end

    // capture pins on write end; software write otherwise; one byte
    wire [DATA_W-1:0] latch_next = write_end_w ? byte_port_pins_in :
                                   latch_wr    ? latch_wdata : latch_reg;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) latch_reg <= '0;
        else             latch_reg <= latch_next;
    end

    // drive while reading; new data shows at once; release at end
    wire drive_next = (state_next == sbp_pkg::SBP_READ);
    wire irq_hi_next = irqf_next & (~irq_priority_enable | prio_next);
    wire irq_lo_next = irqf_next & irq_priority_enable & ~prio_next;
    // upper nibble of direction: ibf, obf, overflow slot, mode
    wire [3:0] dir_hi_next = {ibf_next, obf_next, 1'b0, slave_port_mode_bit};

    // Registered outputs
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            byte_port_pins_out       <= '0;
            byte_port_pins_oe        <= '0;
            latch_rdata              <= '0;
            strobe_port_direction_hi <= sbp_pkg::DIR_RESET[7:4];
            slave_port_irq_flag      <= 1'b0;
            input_full_flag          <= 1'b0;
            output_full_flag         <= 1'b0;
            slave_port_irq_priority  <= sbp_pkg::PRIO_RESET;
            irq_high                 <= 1'b0;
            irq_low                  <= 1'b0;
            port_active              <= 1'b0;
        end else begin
            byte_port_pins_out       <= latch_next;
            byte_port_pins_oe        <= {DATA_W{drive_next}};
            latch_rdata              <= latch_next;
            strobe_port_direction_hi <= dir_hi_next;
            slave_port_irq_flag      <= irqf_next;
            input_full_flag          <= ibf_next;
            output_full_flag         <= obf_next;
            slave_port_irq_priority  <= prio_next;
            irq_high                 <= irq_hi_next;
            irq_low                  <= irq_lo_next;
            port_active              <= active_w;
        end
    end

    // Assertions
    // write end sets flags next cycle
    a_write_end_flags: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        write_end_w |=> (input_full_flag && slave_port_irq_flag))
        else $error("write end did not set flags");

    // read end releases pins and sets irq flag
    a_read_end_rel: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        read_end_w |=> (byte_port_pins_oe == '0 && slave_port_irq_flag))
        else $error("read end did not release pins");

    a_read_clr_obf: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (state_reg == sbp_pkg::SBP_READ) |=> !output_full_flag)
        else $error("output-full set during read");

    a_read_drives: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (state_reg == sbp_pkg::SBP_READ) |-> byte_port_pins_oe == '1)
        else $error("pins not driven during read");

    // no selected read strobe, no drive
    a_no_read_quiet: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        !rd_low_w |=> byte_port_pins_oe == '0)
        else $error("pins driven without read strobe");

    // software write during read seen on pins
    a_read_wr_pass: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (state_reg == sbp_pkg::SBP_READ && rd_low_w && latch_wr && !write_end_w)
        |=> byte_port_pins_out == $past(latch_wdata))
        else $error("software data not presented");

    // software write outside a read sets output-full
    a_obf_set: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (latch_wr && !in_read_w) |=> output_full_flag)
        else $error("output-full not set by software write");

    a_write_capture: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        write_end_w |=> latch_rdata == $past(byte_port_pins_in))
        else $error("write data not captured");

    // latch byte holds without a write
    a_latch_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (!write_end_w && !latch_wr) |=> latch_rdata == $past(latch_rdata))
        else $error("latch changed without a write");

    // input-full clear works when no write ends
    a_ibf_clear: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (input_full_clr && !write_end_w) |=> !input_full_flag)
        else $error("input-full not cleared");

    a_inactive_quiet: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        !active_w[*2] |-> byte_port_pins_oe == '0)
        else $error("pins driven while inactive");

    a_active_copy: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        active_w |=> port_active)
        else $error("active status missing");

    a_dir_nibble: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        strobe_port_direction_hi[3:1] == {input_full_flag, output_full_flag, 1'b0})
        else $error("direction nibble out of step");

    a_prio_low: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (irq_low |-> (irq_priority_enable || $past(irq_priority_enable)) && !irq_high))
        else $error("low irq without priority");

    a_prio_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        !$past(prio_wr) |-> slave_port_irq_priority == $past(slave_port_irq_priority))
        else $error("priority changed without a write");

    a_prio_gate: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        $past(!irq_priority_enable) && slave_port_irq_flag |-> irq_high)
        else $error("priority used while disabled");

    // strobe reaches state after sync delay
    a_sync_delay: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (state_reg == sbp_pkg::SBP_IDLE && active_w && !strobe_port_pins[sbp_pkg::CS_PIN]
         && !strobe_port_pins[sbp_pkg::WR_PIN])[*3] |=> state_reg == sbp_pkg::SBP_WRITE)
        else $error("write not seen after sync");

    // Main transfer scenarios
    c_write: cover property (@(posedge core_clk) disable iff (!rst_sync_n) write_end_w);
    c_read: cover property (@(posedge core_clk) disable iff (!rst_sync_n) read_end_w);
    c_read_wr: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
        (state_reg == sbp_pkg::SBP_READ) && latch_wr);
    // Low-priority routing and a strobe seen while inactive
    c_prio_low: cover property (@(posedge core_clk) disable iff (!rst_sync_n) irq_low);
    c_inactive: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
        !active_w && !strobe_port_pins[sbp_pkg::CS_PIN] && !strobe_port_pins[sbp_pkg::WR_PIN]);
endmodule

/* File: common/sbp_pkg.sv */
// Shared constants for the parallel slave byte port
package sbp_pkg;
    // Data width of the byte port
    localparam int unsigned DATA_W = 8;
    // Strobe pin positions on the strobe port
    localparam int unsigned RD_PIN = 0;
    localparam int unsigned WR_PIN = 1;
    localparam int unsigned CS_PIN = 2;
    // Direction register field positions and reset value
    localparam int unsigned DIR_MODE_BIT = 4;
    localparam logic [7:0]  DIR_RESET    = 8'h07;
    // Converter pin config range for digital strobes
    localparam logic [3:0]  CFG_DIGITAL_LO = 4'ha;
    localparam logic [3:0]  CFG_DIGITAL_HI = 4'hf;
    // Priority bit reset value
    localparam logic        PRIO_RESET = 1'b1;
    // Synchroniser stages
    localparam int unsigned SYNC_STAGES = 2;
    // Transfer states
    typedef enum logic [1:0] {SBP_IDLE, SBP_WRITE, SBP_READ} sbp_state_t;
endpackage

/* File: rtl/sbp_sync.sv */
// Multi-stage level synchroniser for one strobe input
`timescale 1ns/100ps
module sbp_sync #(
    parameter int unsigned STAGES = 2,
    parameter logic        INIT   = 1'b1
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_out
);
    logic [STAGES-1:0] chain_reg;

    // Elaboration check: a single stage cannot synchronise
    if (STAGES < 2) begin : g_stage_check
        $error("sbp_sync needs at least two stages");
    end

    // Shift chain; only the last stage is used
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) chain_reg <= {STAGES{INIT}};
        else        chain_reg <= {chain_reg[STAGES-2:0], async_in};
    end

    assign sync_out = chain_reg[STAGES-1];
endmodule

/* File: tb/sbp_host_model.sv */
// External processor model driving strobes and the data bus
`timescale 1ns/100ps
module sbp_host_model (
    // Clock used only to pace the strobes and the bus data
    input  wire logic       core_clk,
    // Resolved data bus level
    input  wire logic [7:0] pins,
    // Strobes {select, write, read}, all active low
    output logic [2:0]      strobes,
    // Data put on the bus by this side
    output logic [7:0]      host_data
);
    initial begin
        strobes = 3'h7;
        host_data = 8'h00;
    end

    // strobes are inputs to the device; timed by strobes alone
    task automatic host_write(input logic [7:0] d);
        @(posedge core_clk);
        host_data <= d;
        strobes <= 3'h1;
        repeat (6) @(posedge core_clk);
        strobes <= 3'h7;
        repeat (5) @(posedge core_clk);
        // Released bus shows the inverse, never a stale value
        host_data <= ~d;
        repeat (4) @(posedge core_clk);
    endtask

    // select and read low; byte taken at the last low edge
    task automatic host_read(output logic [7:0] q);
        @(posedge core_clk);
        strobes <= 3'h2;
        repeat (8) @(posedge core_clk);
        q = pins;
        strobes <= 3'h7;
        host_data <= ~host_data;
        repeat (8) @(posedge core_clk);
    endtask
endmodule

/* File: tb/sbp_top_test.sv */
// Self-checking bench for the parallel slave byte port
`timescale 1ns/100ps
module sbp_top_test;
    logic       core_clk = 1'b0;
    logic       rst_n    = 1'b0;
    logic [7:0] pins_out, pins_oe, host_data, pin_wire, latch_rdata, rd_q;
    logic [7:0] latch_wdata = 8'h00;
    logic [3:0] cfg = 4'hc;
    logic [3:0] dir_hi;
    logic [2:0] strobes;
    logic       mode = 1'b0, pwm = 1'b0, latch_wr = 1'b0, irq_clr = 1'b0, ibf_clr = 1'b0;
    logic       prio_wr = 1'b0, prio_wd = 1'b0, prio_en = 1'b0;
    logic       irq_flag, in_full, out_full, prio, irq_high, irq_low, active;
    int         err_count = 0;
    int         checked   = 0;
    int         cycles    = 0;

    // Clock and bus resolution: device wins while it drives
    always #4 core_clk = ~core_clk;
    assign pin_wire = (pins_oe & pins_out) | (~pins_oe & host_data);

    sbp_host_model host_u (.core_clk(core_clk), .pins(pin_wire), .strobes(strobes),
                           .host_data(host_data));

    // converter config held in the digital range
    sbp_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .strobe_port_pins(strobes),
        .byte_port_pins_in(pin_wire), .byte_port_pins_out(pins_out),
        .byte_port_pins_oe(pins_oe), .slave_port_mode_bit(mode), .pwm_multi_output(pwm),
        .converter_pin_config(cfg), .latch_wr(latch_wr), .latch_wdata(latch_wdata),
        .latch_rdata(latch_rdata), .irq_flag_clr(irq_clr), .input_full_clr(ibf_clr),
        .prio_wr(prio_wr), .prio_wdata(prio_wd), .irq_priority_enable(prio_en),
        .strobe_port_direction_hi(dir_hi), .slave_port_irq_flag(irq_flag),
        .input_full_flag(in_full), .output_full_flag(out_full),
        .slave_port_irq_priority(prio), .irq_high(irq_high), .irq_low(irq_low),
        .port_active(active));

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_flag(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic sw_write(input logic [7:0] d);
        @(posedge core_clk);
        latch_wr <= 1'b1;
        latch_wdata <= d;
        @(posedge core_clk);
        latch_wr <= 1'b0;
    endtask

    task automatic clr_flags();
        @(posedge core_clk);
        irq_clr <= 1'b1;
        ibf_clr <= 1'b1;
        @(posedge core_clk);
        irq_clr <= 1'b0;
        ibf_clr <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    // Hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        chk_flag("priority", 1'b1, prio);
        chk_byte("dir_hi", 8'h00, {4'h0, dir_hi});
        chk_byte("pins_oe", 8'h00, pins_oe);
        @(posedge core_clk);
        mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk_flag("port_active", 1'b1, active);
        chk_byte("dir_hi", 8'h01, {4'h0, dir_hi});
        host_u.host_write(8'ha5);
        #1;
        chk_flag("input_full", 1'b1, in_full);
        chk_flag("irq_flag", 1'b1, irq_flag);
        chk_byte("latch", 8'ha5, latch_rdata);
        chk_byte("dir_hi", 8'h09, {4'h0, dir_hi});
        clr_flags();
        #1;
        chk_flag("irq_flag", 1'b0, irq_flag);
        chk_flag("input_full", 1'b0, in_full);
        sw_write(8'h3c);
        repeat (2) @(posedge core_clk);
        #1;
        chk_flag("output_full", 1'b1, out_full);
        chk_byte("dir_hi", 8'h05, {4'h0, dir_hi});
        host_u.host_read(rd_q);
        #1;
        chk_byte("read_byte", 8'h3c, rd_q);
        chk_flag("output_full", 1'b0, out_full);
        chk_flag("irq_flag", 1'b1, irq_flag);
        chk_byte("pins_oe", 8'h00, pins_oe);
        clr_flags();
        fork
            host_u.host_read(rd_q);
            begin
                repeat (4) @(posedge core_clk);
                sw_write(8'h5a);
            end
        join
        #1;
        chk_byte("read_byte", 8'h5a, rd_q);
        chk_flag("output_full", 1'b0, out_full);
        clr_flags();
        pwm <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk_flag("port_active", 1'b0, active);
        host_u.host_write(8'h77);
        #1;
        chk_flag("input_full", 1'b0, in_full);
        chk_flag("irq_flag", 1'b0, irq_flag);
        chk_byte("latch", 8'h5a, latch_rdata);
        @(posedge core_clk);
        pwm <= 1'b0;
        host_u.host_write(8'hc3);
        #1;
        chk_byte("latch", 8'hc3, latch_rdata);
        chk_flag("irq_high", 1'b1, irq_high);
        chk_flag("irq_low", 1'b0, irq_low);
        @(posedge core_clk);
        prio_wr <= 1'b1;
        prio_wd <= 1'b0;
        prio_en <= 1'b1;
        @(posedge core_clk);
        prio_wr <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk_flag("priority", 1'b0, prio);
        chk_flag("irq_low", 1'b1, irq_low);
        chk_flag("irq_high", 1'b0, irq_high);
        @(posedge core_clk);
        prio_en <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk_flag("irq_high", 1'b1, irq_high);
        chk_flag("irq_low", 1'b0, irq_low);
        // Mid-run reset returns the priority bit to one
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        chk_flag("priority", 1'b1, prio);
        chk_flag("irq_flag", 1'b0, irq_flag);
        chk_byte("pins_oe", 8'h00, pins_oe);
        end_sim();
    end
endmodule
